/* hw/chan_div_pkg.sv */
// constants for the output channel divider block
`default_nettype none
package chan_div_pkg;
   // register byte addresses
   localparam logic [8:0] ADDR_B_ROUTING = 9'h195;
   localparam logic [8:0] ADDR_C_LENGTHS = 9'h196;
   localparam logic [8:0] ADDR_C_CONTROL = 9'h197;
   localparam logic [8:0] ADDR_C_ROUTING = 9'h198;
   localparam logic [8:0] ADDR_STATUS = 9'h1F0;
   // field positions in the phase length register
   localparam int LOW_LEN_MSB = 7;
   localparam int LOW_LEN_LSB = 4;
   localparam int HIGH_LEN_MSB = 3;
   localparam int HIGH_LEN_LSB = 0;
   // field positions in the control register
   localparam int CTL_BYPASS = 7;
   localparam int CTL_SYNC_EXEMPT = 6;
   localparam int CTL_FORCE_STATIC = 5;
   localparam int CTL_START_HIGH = 4;
   localparam int PHASE_MSB = 3;
   localparam int PHASE_LSB = 0;
   // field positions in the routing registers
   localparam int RT_DIRECT = 1;
   localparam int RT_DCC_OFF = 0;
   // field positions in the status register
   localparam int ST_DIV_OUT = 0;
   localparam int ST_RUNNING = 1;
   localparam int ST_SYNC_HELD = 2;
   // reset values
   localparam logic [7:0] RST_C_LENGTHS = 8'h00;
   localparam logic [7:0] RST_C_CONTROL = 8'h00;
   localparam logic [1:0] RST_ROUTING = 2'h0;
   // divider sequencing states
   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_DELAY = 2'b01,
      ST_RUN = 2'b10
   } div_state_e;
endpackage : chan_div_pkg
`default_nettype wire

/* hw/div_cfg_if.sv */
// configuration and status bundle between register file and divider core
`timescale 1ns/1ps
`default_nettype none
interface div_cfg_if;
   logic [3:0] low_len;
   logic [3:0] high_len;
   logic [3:0] phase_off;
   logic start_high;
   logic hold;
   logic edge_en;
   logic div_out;
   logic running;
   modport regs (output low_len, output high_len, output phase_off, output start_high, output hold,
                 output edge_en, input div_out, input running);
   modport core (input low_len, input high_len, input phase_off, input start_high, input hold,
                 input edge_en, output div_out, output running);
endinterface : div_cfg_if
`default_nettype wire

/* hw/pin_sync.sv */
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input wire logic clk,
   input wire logic srst,
   input wire logic rst_val,
   input wire logic pin,
   output logic level
);
   logic meta_ff;
   logic level_ff;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_ff <= 1'b0;
         level_ff <= 1'b0;
      end else begin
         meta_ff <= pin ^ rst_val;
         level_ff <= meta_ff;
      end
   end

   assign level = level_ff ^ rst_val;
endmodule : pin_sync
`default_nettype wire

/* hw/divider_core.sv */
// low/high phase counting divider with start delay
`timescale 1ns/1ps
`default_nettype none
module divider_core (
   input wire logic clk,
   input wire logic srst,
   div_cfg_if.core cfg
);
   chan_div_pkg::div_state_e state_ff;
   chan_div_pkg::div_state_e nxt_state;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic out_ff;
   logic nxt_out;
   logic [3:0] cur_len;
   logic phase_end;

   // length of the phase in progress, field plus one cycles
   assign cur_len = out_ff ? cfg.high_len : cfg.low_len;
   assign phase_end = (cnt_ff == cur_len);

   // sequencing: hold at start level, wait phase offset, then toggle per phase
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_out = out_ff;
      case (state_ff)
         chan_div_pkg::ST_HOLD: begin
            nxt_out = cfg.start_high;
            nxt_cnt = cfg.phase_off;
            if (!cfg.hold) begin
               nxt_state = chan_div_pkg::ST_DELAY;
            end
         end
         chan_div_pkg::ST_DELAY: begin
            if (cfg.edge_en) begin
               if (cnt_ff == 4'h0) begin
                  nxt_state = chan_div_pkg::ST_RUN;
                  nxt_cnt = 4'h1;
               end else begin
                  nxt_cnt = cnt_ff - 4'h1;
               end
            end
         end
         chan_div_pkg::ST_RUN: begin
            if (cfg.edge_en) begin
               if (phase_end) begin
                  nxt_out = ~out_ff;
                  nxt_cnt = 4'h0;
               end else begin
                  nxt_cnt = cnt_ff + 4'h1;
               end
            end
         end
         default: begin
            nxt_state = chan_div_pkg::ST_HOLD;
         end
      endcase
      // hold wins in every state so a sync or bypass restarts cleanly
      if (cfg.hold) begin
         nxt_state = chan_div_pkg::ST_HOLD;
         nxt_out = cfg.start_high;
         nxt_cnt = cfg.phase_off;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff <= chan_div_pkg::ST_HOLD;
         cnt_ff <= 4'h0;
         out_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         out_ff <= nxt_out;
      end
   end

   assign cfg.div_out = out_ff;
   assign cfg.running = (state_ff == chan_div_pkg::ST_RUN);
endmodule : divider_core
`default_nettype wire

/* hw/output_channel_divider.sv */
// channel c divider with its register file and output routing, plus channel b routing
`timescale 1ns/1ps
`default_nettype none
module output_channel_divider (
   input wire logic clk,
   input wire logic srst,
   input wire logic [8:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   input wire logic dist_clk_in,
   input wire logic sync_req_n,
   input wire logic global_route_sel,
   input wire logic chan_b_div_in,
   output logic pair_c_output_first,
   output logic pair_c_output_second,
   output logic pair_b_output_first,
   output logic pair_b_output_second,
   output logic chan_c_dcc_enable,
   output logic chan_b_dcc_enable
);
   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] lengths_ff;
   logic [7:0] control_ff;
   logic [1:0] c_routing_ff;
   logic [1:0] b_routing_ff;
   logic [7:0] rd_data_ff;
   logic [7:0] nxt_rd_data;
   logic in_clk_prev_ff;
   logic pair_c_ff;
   logic pair_b_ff;
   // bundle to the core, declared early because the output mux reads it
   div_cfg_if cfg ();

   // decode
   logic sel_b_rt;
   logic sel_c_len;
   logic sel_c_ctl;
   logic sel_c_rt;
   logic sel_status;
   assign sel_b_rt = (addr == chan_div_pkg::ADDR_B_ROUTING);
   assign sel_c_len = (addr == chan_div_pkg::ADDR_C_LENGTHS);
   assign sel_c_ctl = (addr == chan_div_pkg::ADDR_C_CONTROL);
   assign sel_c_rt = (addr == chan_div_pkg::ADDR_C_ROUTING);
   assign sel_status = (addr == chan_div_pkg::ADDR_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic in_clk_lvl;
   logic sync_n_lvl;

   pin_sync u_clk_sync (
      .clk(clk),
      .srst(srst),
      .rst_val(1'b0),
      .pin(dist_clk_in),
      .level(in_clk_lvl)
   );

   // sync pin idles high, so its synchroniser resets to the released level
   pin_sync u_sync_sync (
      .clk(clk),
      .srst(srst),
      .rst_val(1'b1),
      .pin(sync_req_n),
      .level(sync_n_lvl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // control decode
   logic bypass;
   logic sync_exempt;
   logic force_static;
   logic start_high;
   logic force_eff;
   logic sync_active;
   logic in_edge;
   logic div_level;
   logic c_direct_eff;
   logic b_direct_eff;
   logic c_level;
   logic b_level;

   assign bypass = control_ff[chan_div_pkg::CTL_BYPASS];
   assign sync_exempt = control_ff[chan_div_pkg::CTL_SYNC_EXEMPT];
   assign force_static = control_ff[chan_div_pkg::CTL_FORCE_STATIC];
   assign start_high = control_ff[chan_div_pkg::CTL_START_HIGH];
   assign sync_active = ~sync_n_lvl & ~sync_exempt;
   assign force_eff = force_static & sync_exempt & ~bypass;
   assign in_edge = in_clk_lvl & ~in_clk_prev_ff;

   // divider level after bypass and forcing
   assign div_level = bypass ? in_clk_lvl :
                      force_eff ? start_high :
                      cfg.div_out;

   // direct routing only counts while the global selector is clear
   assign c_direct_eff = c_routing_ff[chan_div_pkg::RT_DIRECT] & ~global_route_sel;
   assign b_direct_eff = b_routing_ff[chan_div_pkg::RT_DIRECT] & ~global_route_sel;
   assign c_level = c_direct_eff ? in_clk_lvl : div_level;
   assign b_level = b_direct_eff ? in_clk_lvl : chan_b_div_in;

   ////////////////////////////////////////////////////////////////////////////
   // divider core
   assign cfg.low_len = lengths_ff[chan_div_pkg::LOW_LEN_MSB:chan_div_pkg::LOW_LEN_LSB];
   assign cfg.high_len = lengths_ff[chan_div_pkg::HIGH_LEN_MSB:chan_div_pkg::HIGH_LEN_LSB];
   assign cfg.phase_off = control_ff[chan_div_pkg::PHASE_MSB:chan_div_pkg::PHASE_LSB];
   assign cfg.start_high = start_high;
   // bypass holds the counter at its start state; forcing holds it at start too
   assign cfg.hold = bypass | sync_active | force_eff;
   assign cfg.edge_en = in_edge;

   divider_core u_core (
      .clk(clk),
      .srst(srst),
      .cfg(cfg)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge clk) begin
      if (srst) begin
         lengths_ff <= chan_div_pkg::RST_C_LENGTHS;
         control_ff <= chan_div_pkg::RST_C_CONTROL;
         c_routing_ff <= chan_div_pkg::RST_ROUTING;
         b_routing_ff <= chan_div_pkg::RST_ROUTING;
      end else if (wr_stb) begin
         if (sel_c_len) begin
            lengths_ff <= wr_data;
         end
         if (sel_c_ctl) begin
            control_ff <= wr_data;
         end
         if (sel_c_rt) begin
            c_routing_ff <= wr_data[1:0];
         end
         if (sel_b_rt) begin
            b_routing_ff <= wr_data[1:0];
         end
      end
   end

   // read mux; unmapped addresses and upper routing bits read zero
   always_comb begin
      nxt_rd_data = 8'h00;
      if (sel_c_len) begin
         nxt_rd_data = lengths_ff;
      end else if (sel_c_ctl) begin
         nxt_rd_data = control_ff;
      end else if (sel_c_rt) begin
         nxt_rd_data = {6'h00, c_routing_ff};
      end else if (sel_b_rt) begin
         nxt_rd_data = {6'h00, b_routing_ff};
      end else if (sel_status) begin
         nxt_rd_data[chan_div_pkg::ST_DIV_OUT] = div_level;
         nxt_rd_data[chan_div_pkg::ST_RUNNING] = cfg.running;
         nxt_rd_data[chan_div_pkg::ST_SYNC_HELD] = sync_active;
      end
   end

   // read data stands one cycle after the strobe only
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_data_ff <= 8'h00;
      end else begin
         rd_data_ff <= rd_stb ? nxt_rd_data : 8'h00;
      end
   end

   // output pair registers; second output is the complement
   always_ff @(posedge clk) begin
      if (srst) begin
         in_clk_prev_ff <= 1'b0;
         pair_c_ff <= 1'b0;
         pair_b_ff <= 1'b0;
      end else begin
         in_clk_prev_ff <= in_clk_lvl;
         pair_c_ff <= c_level;
         pair_b_ff <= b_level;
      end
   end

   assign rd_data = rd_data_ff;
   assign pair_c_output_first = pair_c_ff;
   assign pair_c_output_second = ~pair_c_ff;
   assign pair_b_output_first = pair_b_ff;
   assign pair_b_output_second = ~pair_b_ff;
   // correction itself sits in the analog output stage
   assign chan_c_dcc_enable = ~c_routing_ff[chan_div_pkg::RT_DCC_OFF];
   assign chan_b_dcc_enable = ~b_routing_ff[chan_div_pkg::RT_DCC_OFF];
endmodule : output_channel_divider
`default_nettype wire

/* bench/output_channel_divider_chk.sv */
// port assertions for the output channel divider
`timescale 1ns/1ps
`default_nettype none
module output_channel_divider_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic [8:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic sync_req_n,
   input wire logic global_route_sel,
   input wire logic chan_b_div_in,
   input wire logic pair_c_output_first,
   input wire logic pair_c_output_second,
   input wire logic pair_b_output_first,
   input wire logic pair_b_output_second,
   input wire logic chan_c_dcc_enable,
   input wire logic chan_b_dcc_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic [7:0] ctl_ff;
   logic [1:0] rtc_ff;
   logic [1:0] rtb_ff;
   logic [3:0] settle_ff;
   logic sync_d_ff;
   logic glob_d_ff;
   // decoded conditions from the shadow settings
   wire logic direct_c = rtc_ff[1] && !global_route_sel;
   wire logic force_on = ctl_ff[6] && ctl_ff[5] && !ctl_ff[7];
   wire logic sync_on = !sync_req_n && !ctl_ff[6] && !ctl_ff[7];
   wire logic quiet = settle_ff == 4'hF;
   wire logic moved = wr_stb || sync_req_n != sync_d_ff || global_route_sel != glob_d_ff;
   ////////////////////////////////////////////////////////////////
   // shadow of written settings; the quiet count hides synchroniser delay
   always_ff @(posedge clk) begin
      sync_d_ff <= sync_req_n;
      glob_d_ff <= global_route_sel;
      settle_ff <= (srst || moved) ? 4'h0 : settle_ff + {3'h0, !quiet};
      if (srst) begin
         ctl_ff <= 8'h00;
         rtc_ff <= 2'h0;
         rtb_ff <= 2'h0;
      end else if (wr_stb) begin
         if (addr == chan_div_pkg::ADDR_C_CONTROL) ctl_ff <= wr_data;
         if (addr == chan_div_pkg::ADDR_C_ROUTING) rtc_ff <= wr_data[1:0];
         if (addr == chan_div_pkg::ADDR_B_ROUTING) rtb_ff <= wr_data[1:0];
      end
   end
   ////////////////////////////////////////////////////////////////
   a_static_level: assert property (quiet && force_on && !direct_c |-> pair_c_output_first == ctl_ff[4])
      else $error("forced level differs from start level");
   a_sync_hold: assert property (quiet && sync_on && !direct_c |-> pair_c_output_first == ctl_ff[4])
      else $error("output moved while sync held");
   a_dcc_c_match: assert property (chan_c_dcc_enable == !rtc_ff[0])
      else $error("channel c correction enable wrong");
   a_dcc_b_match: assert property (chan_b_dcc_enable == !rtb_ff[0])
      else $error("channel b correction enable wrong");
   a_pair_c_diff: assert property (pair_c_output_second == !pair_c_output_first)
      else $error("channel c pair not complementary");
   a_pair_b_diff: assert property (pair_b_output_second == !pair_b_output_first)
      else $error("channel b pair not complementary");
   a_b_divided_path: assert property (quiet && !(rtb_ff[1] && !global_route_sel) |=>
      pair_b_output_first == $past(chan_b_div_in)) else $error("channel b not fed from its divider");
   a_reset_start: assert property ($fell(srst) |-> !pair_c_output_first && !pair_b_output_first)
      else $error("outputs not low after reset");
   a_rd_idle: assert property (!rd_stb |=> rd_data == 8'h00)
      else $error("read data outside its cycle");
   cover property (quiet && force_on);
   cover property (quiet && sync_on);
   cover property (quiet && direct_c);
endmodule : output_channel_divider_chk
bind output_channel_divider output_channel_divider_chk output_channel_divider_chk_i (.clk(clk), .srst(srst),
   .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .sync_req_n(sync_req_n),
   .global_route_sel(global_route_sel), .chan_b_div_in(chan_b_div_in), .pair_c_output_first(pair_c_output_first),
   .pair_c_output_second(pair_c_output_second), .pair_b_output_first(pair_b_output_first),
   .pair_b_output_second(pair_b_output_second), .chan_c_dcc_enable(chan_c_dcc_enable),
   .chan_b_dcc_enable(chan_b_dcc_enable));
`default_nettype wire

/* bench/output_channel_divider_tb_top.sv */
// self-checking bench for the output channel divider
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module output_channel_divider_tb_top;
   logic clk, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, sync_req_n = 1'b1, global_route_sel = 1'b0;
   logic dist_clk_in = 1'b0, chan_b_div_in = 1'b0, pcf, pcs, pbf, pbs, dcc_c, dcc_b, lvl;
   logic [8:0] addr = 9'h000;
   logic [7:0] wr_data = 8'h00, rd_data, d, len;
   logic [8:0] regs [5] = '{9'h195, 9'h196, 9'h197, 9'h198, 9'h1FF};
   logic [7:0] msk [5] = '{8'h03, 8'hFF, 8'hFF, 8'h03, 8'h00};
   int error_cnt = 0, cmp_count = 0, cyc = 0, hi, lo, nt;
   int q[$] = '{8'h00, 8'h77, 8'hF0};
   output_channel_divider output_channel_divider_i (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .dist_clk_in(dist_clk_in), .sync_req_n(sync_req_n),
      .global_route_sel(global_route_sel), .chan_b_div_in(chan_b_div_in), .pair_c_output_first(pcf),
      .pair_c_output_second(pcs), .pair_b_output_first(pbf), .pair_b_output_second(pbs),
      .chan_c_dcc_enable(dcc_c), .chan_b_dcc_enable(dcc_b));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   // input clock of 8 cycles stays slower than the edge detector's limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      dist_clk_in <= cyc[2];
      chan_b_div_in <= (cyc % 12) < 6;
      if (cyc == 40000) begin
         error_cnt++;
         results;
      end
   end
   task wr(input logic [8:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr
   task rd(input logic [8:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 v = rd_data;
   endtask : rd
   // last complete high and low runs in clock cycles; first run is partial
   task meas(input bit sel);
      logic v, p;
      int run;
      run = 0;
      nt = 0;
      hi = -1;
      lo = -1;
      repeat (60) @(posedge clk);
      #1 p = sel ? pbf : pcf;
      repeat (600) begin
         @(posedge clk);
         #1 v = sel ? pbf : pcf;
         if (v !== p) begin
            if (nt > 0 && p) hi = run;
            if (nt > 0 && !p) lo = run;
            nt++;
            run = 0;
         end
         run++;
         p = v;
      end
      lvl = p;
      // hand back on an edge so callers drive inputs there
      @(posedge clk);
   endtask : meas
   function int half_len(input logic [3:0] n);
      return (int'(n) + 1) * 8;
   endfunction : half_len
   task chk_run(input string nm, input bit sel, input int eh, input int el);
      meas(sel);
      `CHK(nm, eh, hi)
      `CHK(nm, el, lo)
   endtask : chk_run
   task chk_static(input string nm, input logic ex, input logic [7:0] est);
      meas(1'b0);
      `CHK(nm, 0, nt)
      `CHK(nm, ex, lvl)
      rd(chan_div_pkg::ADDR_STATUS, d);
      `CHK(nm, est, d)
   endtask : chk_static
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h867B));
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      // reset values, random read-back, unmapped place reads zero
      foreach (regs[i]) begin
         rd(regs[i], d);
         `CHK("reset value", 8'h00, d)
         len = 8'($urandom);
         wr(regs[i], len);
         rd(regs[i], d);
         `CHK("read back", len & msk[i], d)
         wr(regs[i], 8'h00);
      end
      wr(chan_div_pkg::ADDR_C_ROUTING, 8'h01);
      wr(chan_div_pkg::ADDR_B_ROUTING, 8'h01);
      @(negedge clk);
      `CHK("dcc c", 1'b0, dcc_c)
      `CHK("dcc b", 1'b0, dcc_b)
      wr(chan_div_pkg::ADDR_C_ROUTING, 8'h00);
      wr(chan_div_pkg::ADDR_B_ROUTING, 8'h00);
      $display("test registers done");
      // boundary and random lengths; model is (field + 1) input periods
      repeat (3) q.push_back($urandom % 256);
      while (q.size() > 0) begin
         len = 8'(q.pop_front());
         wr(chan_div_pkg::ADDR_C_LENGTHS, len);
         chk_run("divided c", 1'b0, half_len(len[3:0]), half_len(len[7:4]));
      end
      $display("test lengths done");
      // sync held obeyed unless exempt
      wr(chan_div_pkg::ADDR_C_LENGTHS, 8'h11);
      sync_req_n <= 1'b0;
      wr(chan_div_pkg::ADDR_C_CONTROL, 8'h10);
      chk_static("sync high", 1'b1, 8'h05);
      wr(chan_div_pkg::ADDR_C_CONTROL, 8'h00);
      chk_static("sync low", 1'b0, 8'h04);
      wr(chan_div_pkg::ADDR_C_CONTROL, 8'h40);
      chk_run("sync exempt", 1'b0, 16, 16);
      sync_req_n <= 1'b1;
      $display("test sync done");
      // force static and bypass combinations
      wr(chan_div_pkg::ADDR_C_CONTROL, 8'h70);
      chk_static("force high", 1'b1, 8'h01);
      wr(chan_div_pkg::ADDR_C_CONTROL, 8'h60);
      chk_static("force low", 1'b0, 8'h00);
      wr(chan_div_pkg::ADDR_C_CONTROL, 8'h30);
      chk_run("force no exempt", 1'b0, 16, 16);
      wr(chan_div_pkg::ADDR_C_CONTROL, 8'hF0);
      chk_run("force in bypass", 1'b0, 4, 4);
      wr(chan_div_pkg::ADDR_C_CONTROL, 8'h80);
      chk_run("bypass", 1'b0, 4, 4);
      wr(chan_div_pkg::ADDR_C_CONTROL, 8'h00);
      $display("test force done");
      // direct routing gated by the global routing bit
      wr(chan_div_pkg::ADDR_C_ROUTING, 8'h02);
      chk_run("direct c", 1'b0, 4, 4);
      global_route_sel <= 1'b1;
      chk_run("direct c gated", 1'b0, 16, 16);
      wr(chan_div_pkg::ADDR_B_ROUTING, 8'h02);
      chk_run("direct b gated", 1'b1, 6, 6);
      global_route_sel <= 1'b0;
      chk_run("direct b", 1'b1, 4, 4);
      wr(chan_div_pkg::ADDR_B_ROUTING, 8'h00);
      chk_run("divided b", 1'b1, 6, 6);
      $display("test routing done");
      results;
   end
endmodule : output_channel_divider_tb_top
`default_nettype wire
